// file: src/time_sync_pkg.sv
// Constants shared by the time sync command block and its clock keeper.
// Assumes a single 20 MHz system clock and a 32-bit AXI4-Lite bus.
package time_sync_pkg;
    // Bus geometry and register map
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] CMD_CTL_OFFSET = 12'h100;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Command and control bit positions
    localparam int BIT_RESET    = 0;
    localparam int BIT_DISABLE  = 1;
    localparam int BIT_ENABLE   = 2;
    localparam int BIT_READ     = 3;
    localparam int BIT_LOAD     = 4;
    localparam int BIT_STEP_SEC = 5;
    localparam int BIT_STEP_NS  = 6;
    localparam int BIT_TEMP     = 7;
    localparam int BIT_CAPTURE  = 8;
    localparam int SEL_LSB      = 9;
    localparam int SEL_MSB      = 12;
    localparam int BIT_TARGET   = 13;
    localparam int CMD_W        = 14;

    // Bits that act as write-one strobes
    localparam logic [13:0] STROBE_MASK = 14'h21FF;
    localparam logic [3:0]  SEL_RESET   = 4'h0;
    localparam logic        PEND_RESET  = 1'b0;

    // Field widths
    localparam int NUM_UNITS = 3;
    localparam int NUM_SETS  = 16;
    localparam int NS_W      = 30;
    localparam int SUBNS_W   = 8;
    localparam int TEMP_W    = 8;

    // Timing: clock rate and nanoseconds added per cycle
    localparam int          CLK_FREQ_HZ    = 20_000_000;
    localparam int          NS_PER_SEC_INT = 1_000_000_000;
    localparam logic [31:0] NS_PER_SEC     = 32'h3B9A_CA00;
    localparam logic [31:0] NS_PER_CYCLE   =
        32'(NS_PER_SEC_INT / CLK_FREQ_HZ);
endpackage

// file: src/time_keeper.sv
// Running protocol clock: seconds and nanoseconds; sub-nanoseconds only loaded or cleared.
// Assumes one-cycle command strobes from the command block.
`timescale 1ns/1ps
`default_nettype none
module time_keeper (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic        step_ns,
    input  wire logic        step_sec,
    input  wire logic        step_dir,
    input  wire logic        temp_start,
    input  wire logic [29:0] step_value,
    input  wire logic [31:0] load_sec,
    input  wire logic [29:0] load_ns,
    input  wire logic [7:0]  load_subns,
    input  wire logic [7:0]  temp_rate,
    input  wire logic [31:0] temp_duration,
    output logic      [31:0] now_sec,
    output logic      [29:0] now_ns,
    output logic      [7:0]  now_subns,
    output logic             temp_active
);
    logic [31:0] temp_left;   // Cycles of temporary rate still due
    logic [31:0] ns_sum;      // Nanoseconds before wrap
    logic [31:0] sec_base;    // Seconds after any step
    logic [31:0] next_sec;
    logic [29:0] next_ns;

    // Sum this cycle's increment, steps and the wrap into seconds
    always_comb begin
        ns_sum = {2'b00, now_ns};
        if (run) begin
            ns_sum = ns_sum + time_sync_pkg::NS_PER_CYCLE;
            if (temp_left != 32'h0000_0000) begin
                ns_sum = ns_sum + {24'h00_0000, temp_rate};
            end
        end
        if (step_ns) begin
            ns_sum = ns_sum + {2'b00, step_value};
        end
        sec_base = now_sec;
        if (step_sec) begin
            // Direction one subtracts, zero adds
            sec_base = step_dir ? now_sec - {2'b00, step_value}
                                : now_sec + {2'b00, step_value};
        end
        if (ns_sum >= time_sync_pkg::NS_PER_SEC) begin
            next_ns  = 30'(ns_sum - time_sync_pkg::NS_PER_SEC);
            next_sec = sec_base + 32'h0000_0001;
        end else begin
            next_ns  = ns_sum[29:0];
            next_sec = sec_base;
        end
    end

    // Clock state: clear beats load, load beats stepping
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && clear)) begin
            now_sec   <= 32'h0000_0000;
            now_ns    <= 30'h0000_0000;
            now_subns <= 8'h00;
        end else if (ce) begin
            if (load) begin
                now_sec   <= load_sec;
                now_ns    <= load_ns;
                now_subns <= load_subns;
            end else begin
                now_sec <= next_sec;
                now_ns  <= next_ns;
            end
        end
    end

    // Temporary rate duration counter
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && clear)) begin
            temp_left   <= 32'h0000_0000;
            temp_active <= 1'b0;
        end else if (ce) begin
            if (temp_start) begin
                temp_left   <= temp_duration;
                temp_active <= temp_duration != 32'h0000_0000;
            end else if (run && temp_left != 32'h0000_0000) begin
                temp_left   <= temp_left - 32'h0000_0001;
                temp_active <= temp_left != 32'h0000_0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: src/time_sync_clock_command.sv
// Command and control register of the time sync unit, AXI4-Lite slave.
// Assumes companion registers outside supply step, load, rate and
// target values, and that frame logic reports frames in flight.
`timescale 1ns/1ps
`default_nettype none
module time_sync_clock_command (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        enable_strap,
    // AXI4-Lite slave
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Companion register values
    input  wire logic [29:0] step_adjust_value,
    input  wire logic        step_adjust_direction,
    input  wire logic [31:0] load_seconds,
    input  wire logic [29:0] load_nanosec,
    input  wire logic [7:0]  load_subnanosec,
    input  wire logic [7:0]  temp_rate_value_reg,
    input  wire logic [31:0] temp_rate_duration,
    input  wire logic [31:0] target_a_seconds_live,
    input  wire logic [29:0] target_a_nanosec_live,
    input  wire logic [31:0] target_b_seconds_live,
    input  wire logic [29:0] target_b_nanosec_live,
    input  wire logic [2:0]  stamp_unit_enable,
    input  wire logic        frames_busy,
    // Snapshot and capture results
    output logic      [31:0] clock_seconds_reg,
    output logic      [29:0] clock_nanosec_reg,
    output logic      [7:0]  clock_subnanosec_reg,
    output logic      [31:0] target_a_seconds_reg,
    output logic      [29:0] target_a_nanosec_reg,
    output logic      [31:0] target_b_seconds_reg,
    output logic      [29:0] target_b_nanosec_reg,
    output logic             cap_write,
    output logic      [3:0]  cap_select,
    output logic      [31:0] cap_seconds,
    output logic      [29:0] cap_nanosec,
    output logic      [15:0] cap_status_set,
    // Unit control
    output logic      [2:0]  port_stamp_enable,
    output logic             accept_frames,
    output logic             temp_rate_active,
    output logic             unit_reset_out,
    output logic             unit_enabled
);
    logic [11:0] aw_addr;      // Held write address
    logic [31:0] w_data;       // Held write data
    logic [3:0]  w_strb;       // Held byte enables
    logic        wr_go;        // Both halves held, response free
    logic        wr_hit;       // Write lands on the command register
    logic [13:0] wr_mask;      // Bits covered by byte enables
    logic [13:0] cmd;          // One-cycle command strobes
    logic [3:0]  capture_sel;  // Manual capture selector field
    logic        enable;       // Global unit enable
    logic        pending;      // Graceful disable waiting for frames
    logic        next_enable;
    logic        next_pending;
    logic [31:0] now_sec;
    logic [29:0] now_ns;
    logic [7:0]  now_subns;

    // Write fires once address and data are both held
    assign wr_go   = !awready && !wready && !bvalid;
    assign wr_hit  = aw_addr == time_sync_pkg::CMD_CTL_OFFSET;
    assign wr_mask = {{6{w_strb[1]}}, {8{w_strb[0]}}};

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_addr <= 12'h000;
        end else if (ce) begin
            if (awready && awvalid) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end else if (wr_go) begin
                awready <= 1'b1;
            end
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (wready && wvalid) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (wr_go) begin
                wready <= 1'b1;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= time_sync_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? time_sync_pkg::RESP_OKAY
                                 : time_sync_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Command strobes last exactly one cycle; zeros never fire
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= 14'h0000;
        end else if (ce) begin
            if (wr_go && wr_hit) begin
                cmd <= w_data[13:0] & wr_mask
                     & time_sync_pkg::STROBE_MASK;
            end else begin
                cmd <= 14'h0000;
            end
        end
    end

    // Manual capture selector field, kept across unit reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_sel <= time_sync_pkg::SEL_RESET;
        end else if (ce && wr_go && wr_hit && w_strb[1]) begin
            capture_sel <= w_data[12:9];
        end
    end

    // Enable and graceful disable; setting beats disabling, unit reset beats both
    always_comb begin
        next_enable  = enable;
        next_pending = pending;
        if (cmd[time_sync_pkg::BIT_RESET]) begin
            next_enable  = 1'b0;
            next_pending = 1'b0;
        end else begin
            if (cmd[time_sync_pkg::BIT_DISABLE]) begin
                next_pending = 1'b1;
            end
            if (pending && !frames_busy) begin
                next_enable  = 1'b0;
                next_pending = 1'b0;
            end
            if (cmd[time_sync_pkg::BIT_ENABLE]) begin
                next_enable  = 1'b1;
                next_pending = 1'b0;
            end
        end
    end

    // Enable state; sync reset catches the strap level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable        <= enable_strap;
            pending       <= time_sync_pkg::PEND_RESET;
            accept_frames <= 1'b0;
            unit_enabled  <= 1'b0;
        end else if (ce) begin
            enable        <= next_enable;
            pending       <= next_pending;
            accept_frames <= next_enable && !next_pending;
            unit_enabled  <= next_enable;
        end
    end

    // Unit reset pulse to the rest of the unit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_reset_out <= 1'b0;
        end else if (ce) begin
            unit_reset_out <= cmd[time_sync_pkg::BIT_RESET];
        end
    end

    // Per-port stamping needs both enables
    generate
        for (genvar u = 0; u < time_sync_pkg::NUM_UNITS; u++) begin : g_unit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    port_stamp_enable[u] <= 1'b0;
                end else if (ce) begin
                    port_stamp_enable[u] <= next_enable
                        && stamp_unit_enable[u];
                end
            end
        end
    endgenerate

    // Running protocol clock
    time_keeper u_keeper (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .run           (enable),
        .clear         (cmd[time_sync_pkg::BIT_RESET]),
        .load          (cmd[time_sync_pkg::BIT_LOAD]),
        .step_ns       (cmd[time_sync_pkg::BIT_STEP_NS]),
        .step_sec      (cmd[time_sync_pkg::BIT_STEP_SEC]),
        .step_dir      (step_adjust_direction),
        .temp_start    (cmd[time_sync_pkg::BIT_TEMP]),
        .step_value    (step_adjust_value),
        .load_sec      (load_seconds),
        .load_ns       (load_nanosec),
        .load_subns    (load_subnanosec),
        .temp_rate     (temp_rate_value_reg),
        .temp_duration (temp_rate_duration),
        .now_sec       (now_sec),
        .now_ns        (now_ns),
        .now_subns     (now_subns),
        .temp_active   (temp_rate_active)
    );

    // Clock and target snapshots
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && cmd[time_sync_pkg::BIT_RESET])) begin
            clock_seconds_reg    <= 32'h0000_0000;
            clock_nanosec_reg    <= 30'h0000_0000;
            clock_subnanosec_reg <= 8'h00;
            target_a_seconds_reg <= 32'h0000_0000;
            target_a_nanosec_reg <= 30'h0000_0000;
            target_b_seconds_reg <= 32'h0000_0000;
            target_b_nanosec_reg <= 30'h0000_0000;
        end else if (ce) begin
            if (cmd[time_sync_pkg::BIT_READ]) begin
                clock_seconds_reg    <= now_sec;
                clock_nanosec_reg    <= now_ns;
                clock_subnanosec_reg <= now_subns;
            end
            if (cmd[time_sync_pkg::BIT_TARGET]) begin
                target_a_seconds_reg <= target_a_seconds_live;
                target_a_nanosec_reg <= target_a_nanosec_live;
                target_b_seconds_reg <= target_b_seconds_live;
                target_b_nanosec_reg <= target_b_nanosec_live;
            end
        end
    end

    // Manual capture write into the selected set and its flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_write      <= 1'b0;
            cap_select     <= 4'h0;
            cap_seconds    <= 32'h0000_0000;
            cap_nanosec    <= 30'h0000_0000;
            cap_status_set <= 16'h0000;
        end else if (ce) begin
            cap_write      <= cmd[time_sync_pkg::BIT_CAPTURE];
            cap_status_set <= 16'h0000;
            if (cmd[time_sync_pkg::BIT_CAPTURE]) begin
                cap_select     <= capture_sel;
                cap_seconds    <= now_sec;
                cap_nanosec    <= now_ns;
                cap_status_set <= 16'h0001 << capture_sel;
            end
        end
    end

    // Read channel; only selector and enable read nonzero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= time_sync_pkg::RESP_OKAY;
        end else if (ce) begin
            if (arready && arvalid) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                if (araddr == time_sync_pkg::CMD_CTL_OFFSET) begin
                    rdata <= {19'h0_0000, capture_sel,
                              6'h00, enable, 2'b00};
                    rresp <= time_sync_pkg::RESP_OKAY;
                end else begin
                    rdata <= 32'h0000_0000;
                    rresp <= time_sync_pkg::RESP_SLVERR;
                end
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_cmd_self_clear: assert property (
        ce && cmd != 14'h0000 |=> cmd == 14'h0000)
        else $error("command strobe held longer than one cycle");
    a_read_zeros: assert property (
        rvalid |-> rdata[31:13] == 19'h0 && rdata[8:3] == 6'h00
                   && rdata[1:0] == 2'b00)
        else $error("strobe or reserved bit read nonzero");
    a_enable_set: assert property (
        ce && cmd[2] && !cmd[0] |=> enable && unit_enabled)
        else $error("enable write did not enable the unit");
    a_enable_holds: assert property (
        ce && enable && !pending && cmd[1:0] == 2'b00 |=> enable)
        else $error("enable dropped without disable or reset");
    a_disable_waits: assert property (
        ce && enable && pending && frames_busy && !cmd[0] |=> enable)
        else $error("enable cleared while frames still busy");
    a_disable_gate: assert property (
        ce && cmd[1] && !cmd[2] && !cmd[0] |=> !accept_frames)
        else $error("new frames allowed after disable");
    a_unit_reset: assert property (
        ce && cmd[0] |=> !enable && !pending && unit_reset_out
                         && port_stamp_enable == 3'b000)
        else $error("unit reset left the unit enabled");
    a_capture_flag: assert property (
        ce && cmd[8] |=> cap_write
            && cap_status_set == (16'h0001 << cap_select))
        else $error("capture flag does not match selected set");
    a_snapshot: assert property (
        ce && cmd[3] && !cmd[0] |=> clock_seconds_reg == $past(now_sec)
            && clock_nanosec_reg == $past(now_ns))
        else $error("clock snapshot does not match running clock");
    a_stamp_gate: assert property (
        port_stamp_enable != 3'b000 |-> $past(next_enable))
        else $error("port stamping without global enable");
    a_strap_value: assert property (
        @(posedge aclk) $rose(aresetn) |-> enable == $past(enable_strap))
        else $error("enable did not take the strap at reset");
endmodule
`default_nettype wire

// file: verification/tb_time_sync_clock_command.sv
// Bench for the time sync command register, driven over AXI4-Lite.
// Assumes the block alone; companion values are driven as levels.
`timescale 1ns/1ps
`default_nettype none
module tb_time_sync_clock_command;
    logic        aclk, aresetn, ce, enable_strap, frames_busy;
    logic        awvalid, wvalid, bready, arvalid, rready, step_dir;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, ld_sec, dur, ta_sec, tb_sec, rd_data;
    logic [3:0]  wstrb;
    logic [29:0] step_val, ld_ns, ta_ns, tb_ns;
    logic [7:0]  ld_sub, rate;
    logic [2:0]  unit_en;
    logic [1:0]  rsp;
    wire logic   awready, wready, bvalid, arready, rvalid, cap_write;
    wire logic   accept_frames, temp_rate_active, unit_reset_out;
    wire logic   unit_enabled;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata, clk_sec, cap_seconds, ta_sec_q, tb_sec_q;
    wire logic [29:0] clk_ns, cap_nanosec, ta_ns_q, tb_ns_q;
    wire logic [7:0]  clk_sub;
    wire logic [3:0]  cap_select;
    wire logic [15:0] cap_status_set;
    wire logic [2:0]  port_stamp_enable;
    int          errors, compares;
    // Only mapped register
    localparam logic [11:0] A = time_sync_pkg::CMD_CTL_OFFSET;

    time_sync_clock_command u_dut (
        .aclk, .aresetn, .ce, .enable_strap, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .step_adjust_value(step_val), .step_adjust_direction(step_dir),
        .load_seconds(ld_sec), .load_nanosec(ld_ns),
        .load_subnanosec(ld_sub), .temp_rate_value_reg(rate),
        .temp_rate_duration(dur), .target_a_seconds_live(ta_sec),
        .target_a_nanosec_live(ta_ns), .target_b_seconds_live(tb_sec),
        .target_b_nanosec_live(tb_ns), .stamp_unit_enable(unit_en),
        .frames_busy, .clock_seconds_reg(clk_sec),
        .clock_nanosec_reg(clk_ns), .clock_subnanosec_reg(clk_sub),
        .target_a_seconds_reg(ta_sec_q), .target_a_nanosec_reg(ta_ns_q),
        .target_b_seconds_reg(tb_sec_q), .target_b_nanosec_reg(tb_ns_q),
        .cap_write, .cap_select, .cap_seconds, .cap_nanosec,
        .cap_status_set, .port_stamp_enable, .accept_frames,
        .temp_rate_active, .unit_reset_out, .unit_enabled
    );

    // Free-running 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A wait that used up its bound ends the run
    task automatic hang(input int n);
        if (n >= 60) begin
            $display("mismatch at %0t: bus wait timed out", $time);
            errors++;
            report_and_stop();
        end
    endtask

    // One write; returns at the edge that takes the response
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rsp = bresp;
        bready <= 1'b0;
        hang(n);
    endtask

    // One read; data and response taken at the rvalid edge
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd_data = rdata;
        rsp = rresp;
        rready <= 1'b0;
        hang(n);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge aclk);
        aresetn      <= 1'b0;
        enable_strap <= strap;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // Clock snapshot, looked at once the strobe has acted
    task automatic snap(input logic [31:0] s, input logic [31:0] ns);
        wr(A, 32'h0000_0008);
        #1;
        chk(clk_sec, s, "snapshot seconds");
        chk(clk_ns, ns, "snapshot nanoseconds");
    endtask

    initial begin
        {aresetn, ce, enable_strap, frames_busy, step_dir} = 5'b0_1100;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0, 4'hF};
        {ld_sec, ld_ns, ld_sub} = {32'h0000_0010, 30'h100, 8'h55};
        {ta_sec, ta_ns, tb_sec, tb_ns} = {32'hA1, 30'hA2, 32'hB1, 30'hB2};
        {step_val, rate, dur, unit_en} = {30'h40, 8'h03, 32'h5, 3'b101};
        {errors, compares} = {32'h0, 32'h0};
        do_reset(1'b1);
        rd(A);
        chk(rd_data, 32'h0000_0004, "strap enable");
        frames_busy <= 1'b1;
        wr(A, 32'h0000_0002);
        #1 chk(accept_frames, 32'h0, "frames still accepted");
        rd(A);
        chk(rd_data, 32'h0000_0004, "enable dropped while busy");
        frames_busy <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(A);
        chk(rd_data, 32'h0000_0000, "enable kept when idle");
        wr(A, 32'h0000_0000);
        rd(A);
        chk(rd_data, 32'h0000_0000, "zero write acted");
        $display("test disable done");
        wr(A, 32'h0000_0010);
        snap(32'h0000_0010, 32'h0000_0100);
        chk(clk_sub, 32'h0000_0055, "snapshot sub ns");
        wr(A, 32'h0000_0040);
        snap(32'h0000_0010, 32'h0000_0140);
        step_val <= 30'h5;
        wr(A, 32'h0000_0020);
        snap(32'h0000_0015, 32'h0000_0140);
        step_dir <= 1'b1;
        wr(A, 32'h0000_0020);
        snap(32'h0000_0010, 32'h0000_0140);
        $display("test clock done");
        wr(A, 32'h0000_1B00);
        #1 chk(cap_write, 32'h1, "capture pulse");
        chk(cap_select, 32'hD, "capture set");
        chk(cap_status_set, 32'h0000_2000, "capture flag");
        chk(cap_seconds, 32'h0000_0010, "capture seconds");
        chk(cap_nanosec, 32'h0000_0140, "capture ns");
        @(posedge aclk);
        #1 chk(cap_write, 32'h0, "capture pulse length");
        rd(A);
        chk(rd_data, 32'h0000_1A00, "readback");
        wr(A, 32'h0000_2000);
        #1 chk({ta_sec_q[15:0], tb_sec_q[15:0]}, 32'h00A1_00B1, "tsec");
        chk({ta_ns_q[15:0], tb_ns_q[15:0]}, 32'h00A2_00B2, "tns");
        $display("test capture done");
        wr(A, 32'h0000_0004);
        #1 chk(unit_enabled, 32'h1, "enable set");
        rd(A);
        chk(rd_data, 32'h0000_0004, "enable readback");
        chk(port_stamp_enable, 32'h5, "port stamping");
        wr(A, 32'h0000_0000);
        rd(A);
        chk(rd_data, 32'h0000_0004, "zero write disabled");
        wr(A, 32'h0000_0080);
        #1 chk(temp_rate_active, 32'h1, "temp rate start");
        repeat (4) @(posedge aclk);
        #1 chk(temp_rate_active, 32'h1, "temp rate held");
        @(posedge aclk);
        #1 chk(temp_rate_active, 32'h0, "temp rate end");
        $display("test enable done");
        wr(A, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        rd(A);
        chk(rd_data, 32'h0000_0000, "disabled before reset");
        wr(A, 32'h0000_0001);
        #1 chk(unit_reset_out, 32'h1, "unit reset pulse");
        chk(clk_sec, 32'h0000_0000, "snapshot cleared");
        wr(12'h104, 32'h0000_0004);
        chk(rsp, time_sync_pkg::RESP_SLVERR, "unmapped write");
        #1 chk(unit_enabled, 32'h0, "unmapped write acted");
        rd(12'h104);
        chk({rd_data[29:0], rsp}, 32'h2, "unmapped read");
        wr(A, 32'h0000_0004);
        do_reset(1'b0);
        rd(A);
        chk(rd_data, 32'h0000_0000, "strap clear");
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
